// ---- hw/asq_adc_sequencer.sv ----
// Sequencer and APB register file of an 8-bit successive-approximation converter.
// Notes on behaviour
// - Channel field value N routes analog input N to the converter.
// - Setting converter_on waits about 30 us, then converts the channel continuously.
// - Each finished conversion loads the result register and sets the done flag.
// - Conversion completion raises an interrupt only as overrun, when the done flag is still set; software polls the flag.
// - Any control write aborts the conversion and clears the flag; sampling restarts afresh, but a running stabilization keeps its count.
// - Reading the result register clears the done flag.
// - Converter_on is software owned; when zero the converter is off.
// - Wait mode changes nothing in converter operation.
// - Halt disables the converter; wake-up repeats the stabilization interval.
// - Control bit 4 always reads as zero.
// - The result register is read only, unsigned, bit 7 most significant.
// - Control and result registers reset to zero.
// - A conversion takes 64 clocks, the first part being sampling.
module asq_adc_sequencer
#(
  parameter int unsigned STAB_CYCLES = asq_pkg::STAB_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asq_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power modes from the core
  input wire logic waitMode,
  input wire logic haltMode,
  // Analog front end
  input wire logic compHigh,
  output asq_pkg::asq_analog_t analogCtrl,
  // Interrupt
  output logic irq
);
  import asq_pkg::*;

  localparam int unsigned STAB_W = $clog2(STAB_CYCLES + 1);

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (STAB_CYCLES < 1)
    begin : gStabCheck
      $error("STAB_CYCLES must be at least one");
    end
  endgenerate

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic regHit(input logic [APB_ADDR_W-1:0] addr, input logic [7:0] idx);
    regHit = (addr == APB_ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic [2:0] bitIndex(input logic [5:0] cnt);
    logic [5:0] k;
    k = cnt - 6'(SAMPLE_CYCLES);
    bitIndex = 3'h7 - k[4:2];
  endfunction

  // ****************************************
  // Registers and wires
  // ****************************************
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic convOn_q;
  logic [CH_W-1:0] chanSel_q;
  logic doneFlag_q;
  logic [DATA_W-1:0] result_q;
  logic [IRQ_W-1:0] irqStat_q;
  logic [IRQ_W-1:0] irqMask_q;
  logic irq_q;
  asq_state_t state_q;
  logic [5:0] convCnt_q;
  logic [STAB_W-1:0] stabCnt_q;
  asq_analog_t analog_q;
  logic compMeta_q;
  logic compSync_q;

  logic apbDone;
  logic apbWr;
  logic apbRd;
  logic ctrlWr;
  logic resultRd;
  logic statWr;
  logic maskWr;
  logic mapped;
  logic convFinish;
  logic stabFinish;
  logic [DATA_W-1:0] finalCode;
  logic [2:0] curBit;
  logic [7:0] ctrlView;

  // ****************************************
  // APB decode
  // ****************************************
  // Effects of a transfer take place only at the edge where pready is seen high.
  assign apbDone = psel & penable & pready_q;
  assign apbWr = apbDone & pwrite;
  assign apbRd = apbDone & ~pwrite;
  assign ctrlWr = apbWr & regHit(paddr, IDX_CTRL);
  assign statWr = apbWr & regHit(paddr, IDX_IRQ_STAT);
  assign maskWr = apbWr & regHit(paddr, IDX_IRQ_MASK);
  assign resultRd = apbRd & regHit(paddr, IDX_RESULT);
  assign mapped = regHit(paddr, IDX_RESULT) | regHit(paddr, IDX_CTRL) | regHit(paddr, IDX_IRQ_STAT)
                  | regHit(paddr, IDX_IRQ_MASK);

  always_comb
  begin
    ctrlView = 8'h00;
    ctrlView[CTRL_DONE_BIT] = doneFlag_q;
    ctrlView[CTRL_ON_BIT] = convOn_q;
    ctrlView[CTRL_CH_LSB +: CH_W] = chanSel_q;
  end

  // One wait cycle in the access phase keeps read data fully registered.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel & penable & ~pready_q)
    begin
      pslverr_q <= ~mapped;
      prdata_q <= 32'h0000_0000;
      if (!pwrite)
      begin
        if (regHit(paddr, IDX_RESULT))
        begin
          // A result landing now is the one returned, since this read clears its flag.
          prdata_q[DATA_W-1:0] <= convFinish ? finalCode : result_q;
        end
        else if (regHit(paddr, IDX_CTRL))
        begin
          prdata_q[7:0] <= ctrlView;
        end
        else if (regHit(paddr, IDX_IRQ_STAT))
        begin
          prdata_q[IRQ_W-1:0] <= irqStat_q;
        end
        else if (regHit(paddr, IDX_IRQ_MASK))
        begin
          prdata_q[IRQ_W-1:0] <= irqMask_q;
        end
      end
    end
    else
    begin
      pslverr_q <= 1'b0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // reset to zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      convOn_q <= CTRL_RESET[CTRL_ON_BIT];
      chanSel_q <= CTRL_RESET[CTRL_CH_LSB +: CH_W];
    end
    else if (ctrlWr)
    begin
      // Bits 6 and 3 are not stored, so a careless write cannot disturb anything.
      convOn_q <= pwdata[CTRL_ON_BIT];
      chanSel_q <= pwdata[CTRL_CH_LSB +: CH_W];
    end
  end

  // ****************************************
  // Comparator synchroniser
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end
    else
    begin
      compMeta_q <= compHigh;
      compSync_q <= compMeta_q;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign curBit = bitIndex(convCnt_q);
  assign stabFinish = (state_q == ASQ_STAB) && (stabCnt_q == STAB_W'(STAB_CYCLES - 1)) && !ctrlWr;
  assign convFinish = (state_q == ASQ_CONVERT) && (convCnt_q == 6'(CONV_CYCLES - 1)) && !ctrlWr
                      && !haltMode && convOn_q;

  always_comb
  begin
    finalCode = analog_q.dacCode;
    if (!compSync_q)
    begin
      finalCode[0] = 1'b0;
    end
  end

  // wait mode is not an input to the sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ASQ_OFF;
      convCnt_q <= 6'h00;
      stabCnt_q <= '0;
    end
    else if (ctrlWr)
    begin
      convCnt_q <= 6'h00;
      if (!pwdata[CTRL_ON_BIT] || haltMode)
      begin
        state_q <= ASQ_OFF;
      end
      else if (state_q == ASQ_OFF)
      begin
        state_q <= ASQ_STAB;
        stabCnt_q <= '0;
      end
      else if (state_q == ASQ_SAMPLE || state_q == ASQ_CONVERT)
      begin
        state_q <= ASQ_SAMPLE;
      end
    end
    else if (haltMode || !convOn_q)
    begin
      state_q <= ASQ_OFF;
      convCnt_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        ASQ_OFF:
        begin
          state_q <= ASQ_STAB;
          stabCnt_q <= '0;
        end
        ASQ_STAB:
        begin
          if (stabFinish)
          begin
            state_q <= ASQ_SAMPLE;
            convCnt_q <= 6'h00;
          end
          else
          begin
            stabCnt_q <= stabCnt_q + 1'b1;
          end
        end
        ASQ_SAMPLE:
        begin
          convCnt_q <= convCnt_q + 1'b1;
          if (convCnt_q == 6'(SAMPLE_CYCLES - 1))
          begin
            state_q <= ASQ_CONVERT;
          end
        end
        ASQ_CONVERT:
        begin
          convCnt_q <= convCnt_q + 1'b1;
          if (convFinish)
          begin
            state_q <= ASQ_SAMPLE;
            convCnt_q <= 6'h00;
          end
        end
        default:
        begin
          state_q <= ASQ_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // Analog drive and approximation register
  // ****************************************
  // The comparator is sampled on the last clock of each bit slot, which covers the two-flop latency.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      analog_q <= '0;
    end
    else
    begin
      analog_q.channel <= (ctrlWr) ? pwdata[CTRL_CH_LSB +: CH_W] : chanSel_q;
      analog_q.powered <= (state_q != ASQ_OFF);
      analog_q.sample <= (state_q == ASQ_SAMPLE) && !ctrlWr;
      if (state_q != ASQ_CONVERT || ctrlWr)
      begin
        analog_q.dacCode <= 8'h00;
      end
      else if (convCnt_q[1:0] == 2'h0)
      begin
        analog_q.dacCode[curBit] <= 1'b1;
      end
      else if (convCnt_q[1:0] == 2'(BIT_CYCLES - 1) && !compSync_q)
      begin
        analog_q.dacCode[curBit] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Result and done flag
  // ****************************************
  // result load
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      result_q <= RESULT_RESET;
    end
    else if (convFinish)
    begin
      result_q <= finalCode;
    end
  end

  // A finish in the same cycle as a result read wins over the clear.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      doneFlag_q <= CTRL_RESET[CTRL_DONE_BIT];
    end
    else if (convFinish)
    begin
      doneFlag_q <= 1'b1;
    end
    else if (ctrlWr || resultRd)
    begin
      doneFlag_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // completion is an interrupt source only as overrun, when the done flag is still set and unread
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irqStat_q <= IRQ_RESET;
    end
    else
    begin
      irqStat_q[IRQ_READY_BIT] <= stabFinish
                                  | (irqStat_q[IRQ_READY_BIT] & ~(statWr & pwdata[IRQ_READY_BIT]));
      irqStat_q[IRQ_OVERRUN_BIT] <= (convFinish & doneFlag_q & ~resultRd)
                                    | (irqStat_q[IRQ_OVERRUN_BIT] & ~(statWr & pwdata[IRQ_OVERRUN_BIT]));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irqMask_q <= IRQ_RESET;
    end
    else if (maskWr)
    begin
      irqMask_q <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign analogCtrl = analog_q;
  assign irq = irq_q;

endmodule

// ---- hw/asq_pkg.sv ----
// Shared constants, types and register map of the 8-bit converter sequencer.
package asq_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned STAB_TIME_NS = 30000;
  // A least time, so the cycle count rounds up.
  localparam int unsigned STAB_CYCLES = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_CYCLES = 64;
  // The half cycle of the sampling phase is rounded up to a whole cycle.
  localparam int unsigned SAMPLE_CYCLES = 32;
  localparam int unsigned BIT_CYCLES = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [7:0] IDX_RESULT = 8'h70;
  localparam logic [7:0] IDX_CTRL = 8'h71;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h72;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h73;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_DONE_BIT = 7;
  localparam int unsigned CTRL_ON_BIT = 5;
  localparam int unsigned CTRL_CH_LSB = 0;
  localparam int unsigned CH_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IRQ_READY_BIT = 0;
  localparam int unsigned IRQ_OVERRUN_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    ASQ_OFF = 2'b00,
    ASQ_STAB = 2'b01,
    ASQ_SAMPLE = 2'b10,
    ASQ_CONVERT = 2'b11
  } asq_state_t;

  typedef struct packed
  {
    logic powered;
    logic sample;
    logic [2:0] channel;
    logic [7:0] dacCode;
  } asq_analog_t;

endpackage

// ---- bench/asq_src_model.sv ----
// Analog sources on the eight multiplexed inputs and an ideal comparator.
module asq_src_model
  import asq_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Analog side
  input wire asq_pkg::asq_analog_t analogCtrl,
  input wire logic [63:0] levels,
  output logic compHigh
);
  logic wander_q = 1'b0;
  // A powered-down comparator has no real answer, so it must not look steady.
  always @(posedge clk_sys)
    wander_q <= ~wander_q;
  assign compHigh = analogCtrl.powered ? (levels[analogCtrl.channel*8 +: 8] >= analogCtrl.dacCode) : wander_q;
endmodule

// ---- bench/asq_chk.sv ----
// Port checker of the converter sequencer.
module asq_chk
  import asq_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = asq_pkg::STAB_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and analog
  input wire logic waitMode,
  input wire logic haltMode,
  input wire logic compHigh,
  input wire asq_pkg::asq_analog_t analogCtrl,
  input wire logic irq
);
  localparam logic [11:0] CTL_ADDR = {2'b00, IDX_CTRL, 2'b00};
  // A control write legally cuts sampling short, so the sampling checks excuse the cycle after it.
  logic ctlWr;
  assign ctlWr = psel && penable && pready && pwrite && (paddr == CTL_ADDR);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence setupSeq;
    psel && !penable;
  endsequence
  sequence answerSeq;
    !pready ##1 pready;
  endsequence
  readyLate_a: assert property (setupSeq |=> answerSeq)
    else $error("ready not in second access cycle");
  readyPulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  errZero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("error read not zero");
  upperZero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  resvZero_a: assert property (pready && !pwrite && paddr == CTL_ADDR |-> !prdata[6] && !prdata[4] && !prdata[3])
    else $error("reserved control bit read one");
  stabQuiet_a: assert property ($rose(analogCtrl.powered) |-> !analogCtrl.sample [*8])
    else $error("sampling during stabilization");
  sampleHold_a: assert property ($rose(analogCtrl.sample)
    |-> (analogCtrl.sample || !analogCtrl.powered || $past(ctlWr)) [*8])
    else $error("sampling phase cut short");
  sampleEnd_a: assert property ($fell(analogCtrl.sample) && analogCtrl.powered && !$past(ctlWr)
    |-> analogCtrl.dacCode == 8'h80)
    else $error("first trial not at midscale");
  offQuiet_a: assert property (!analogCtrl.powered |-> !analogCtrl.sample)
    else $error("sampling while off");
  haltOff_a: assert property (haltMode |-> ##[1:2] !analogCtrl.powered)
    else $error("converter powered in halt");
endmodule
bind asq_adc_sequencer asq_chk #(.STAB_CYCLES(STAB_CYCLES)) chk_inst (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .waitMode(waitMode), .haltMode(haltMode), .compHigh(compHigh), .analogCtrl(analogCtrl), .irq(irq));

// ---- bench/tb.sv ----
// Self-checking bench of the converter sequencer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  // Short stabilization keeps the run brief.
  localparam int unsigned STAB = 20;
  localparam logic [11:0] A_RES = {2'b00, IDX_RESULT, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic waitMode = 1'b0;
  logic haltMode = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic compHigh;
  logic irq;
  asq_analog_t analogCtrl;
  logic [63:0] levels = 64'h0000_0000_0000_0000;
  logic [7:0] seed = 8'h0B;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int check_count = 0;
  always #4 clk_sys = ~clk_sys;
  asq_adc_sequencer #(.STAB_CYCLES(STAB)) asq_adc_sequencer_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waitMode(waitMode), .haltMode(haltMode), .compHigh(compHigh), .analogCtrl(analogCtrl), .irq(irq));
  asq_src_model asq_src_model_inst (.clk_sys(clk_sys), .analogCtrl(analogCtrl), .levels(levels), .compHigh(compHigh));
  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] ctlExp(input logic done, input logic on, input logic [2:0] ch);
    return {24'h00_0000, done, 1'b0, on, 2'b00, ch};
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // One APB transfer; an idle cycle follows so psel is never set twice at one edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (pready !== 1'b1)
      n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_CTL, 32'h0000_0000);
      n++;
    end
    while (rd[CTRL_DONE_BIT] !== 1'b1 && n < 100);
    chk("done flag", 32'h0000_0001, {31'h0, rd[CTRL_DONE_BIT]});
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    for (int i = 1; i < 7; i++)
    begin
      seed = lfsr(seed);
      levels[i*8 +: 8] = seed;
    end
    levels[63:56] = 8'hFF;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, A_RES, 32'h0000_0000);
    chk("result reset", 32'h0000_0000, rd);
    apb(1'b0, A_CTL, 32'h0000_0000);
    chk("control reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h1D0, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    for (int ch = 0; ch < 8; ch++)
    begin
      waitMode <= seed[0];
      // bits 6 and 3 kept zero
      apb(1'b1, A_CTL, {24'h00_0000, 5'b00110, 3'(ch)});
      apb(1'b0, A_CTL, 32'h0000_0000);
      chk("control after write", ctlExp(1'b0, 1'b1, 3'(ch)), rd);
      waitDone();
      apb(1'b0, A_RES, 32'h0000_0000);
      chk("result", {24'h00_0000, levels[ch*8 +: 8]}, rd);
      apb(1'b0, A_CTL, 32'h0000_0000);
      chk("control after read", ctlExp(1'b0, 1'b1, 3'(ch)), rd);
      waitDone();
      seed = lfsr(seed);
    end
    apb(1'b1, A_RES, 32'h0000_00AA);
    apb(1'b0, A_RES, 32'h0000_0000);
    chk("result read only", 32'h0000_00FF, rd);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, A_STAT, 32'h0000_0000);
    chk("stab status", 32'h0000_0001, rd & 32'h0000_0001);
    apb(1'b1, A_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, A_STAT, 32'h0000_0003);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    haltMode <= 1'b1;
    repeat (10) @(posedge clk_sys);
    haltMode <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("irq in restab", 32'h0000_0000, {31'h0, irq});
    repeat (STAB + 4) @(posedge clk_sys);
    chk("irq after restab", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, A_CTL, 32'h0000_0027);
    waitDone();
    apb(1'b1, A_CTL, 32'h0000_0007);
    repeat (200) @(posedge clk_sys);
    apb(1'b0, A_CTL, 32'h0000_0000);
    chk("control while off", ctlExp(1'b0, 1'b0, 3'd7), rd);
    conclude();
  end
endmodule
